// File: cable_diag_loopback.sv
`timescale 1ns/10ps
// Operation
// - pair chosen by manual pair select bit
// - pulses on tx straight, rx crossed
// - pulse-to-echo interval reported as length
// - tdr run drops active link
// - cable length valid only on 100 link
// - loopback bit returns transmit data on receive
// - near loop passes through coding sublayers; here mac_txd is looped back to mac_rxd uncoded
// - col held low in loop unless test
// - transmitters powered down during near loopback
// - far loop echoes line data, isolates mac
// - far loop only in rmii mode
// - connector loopback works at both speeds
// - loopback bit 0 normal, 1 loopback
// - col test within 512 on, 4 off
module cable_diag_loopback
  import cable_diag_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // controller-side data path
  input  wire logic        rmii_mode,
  input  wire logic [3:0]  mac_txd,
  input  wire logic        mac_txen,
  output logic      [3:0]  mac_rxd,
  output logic             mac_rxdv,
  output logic             mac_col,
  // coded line path
  input  wire logic [3:0]  line_rxd,
  input  wire logic        line_rxdv,
  input  wire logic        line_col,
  input  wire logic        link_up,
  input  wire logic        link_100,
  input  wire logic [3:0]  cable_length_code,
  input  wire logic        echo_detect,
  output logic      [3:0]  line_txd,
  output logic             line_txen,
  output logic             tx_power_on,
  output logic             tdr_pulse_tx,
  output logic             tdr_pulse_rx,
  output logic             link_drop
);
  logic [15:0]          basic_ctrl_ff;
  logic [15:0]          mode_ctrl_ff;
  logic [15:0]          special_ctrl_ff;
  logic                 tdr_en_ff;
  logic                 tdr_done_ff;
  logic [TDR_LEN_MSB:0] tdr_len_ff;
  logic [TDR_CNT_W-1:0] tdr_cnt_ff;
  tdr_state_t           tdr_state_ff;
  logic                 col_test;
  logic                 wr_en;
  logic                 near_loop;
  logic                 far_loop;
  logic                 mapped;
  logic [31:0]          nxt_rdata;

  assign wr_en     = psel && penable && pwrite;
  assign near_loop = basic_ctrl_ff[LOOPBACK_BIT];
  assign far_loop  = mode_ctrl_ff[FAR_LOOP_BIT] && rmii_mode;

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_ctrl_ff   <= BASIC_CTRL_RST;
      mode_ctrl_ff    <= MODE_CTRL_RST;
      special_ctrl_ff <= SPECIAL_CTRL_RST;
    end else if (wr_en) begin
      unique case (paddr)
        BASIC_CTRL_OFF:   basic_ctrl_ff   <= {pwdata[15:7], 7'h00};
        MODE_CTRL_OFF:    mode_ctrl_ff    <= pwdata[15:0];
        SPECIAL_CTRL_OFF: special_ctrl_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // tdr enable: software sets, hardware clears when done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdr_en_ff <= 1'b0;
    end else if (tdr_state_ff == TDR_DONE) begin
      tdr_en_ff <= 1'b0;
    end else if (wr_en && paddr == TDR_CTRL_OFF) begin
      tdr_en_ff <= pwdata[TDR_EN_BIT];
    end
  end

  // tdr sequencer: pulse, count until echo or timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdr_state_ff <= TDR_IDLE;
      tdr_cnt_ff   <= '0;
      tdr_len_ff   <= '0;
    end else begin
      unique case (tdr_state_ff)
        TDR_IDLE: if (tdr_en_ff) begin
          tdr_state_ff <= TDR_PULSE;
          tdr_cnt_ff   <= '0;
        end
        TDR_PULSE: tdr_state_ff <= TDR_WAIT;
        TDR_WAIT: begin
          tdr_cnt_ff <= tdr_cnt_ff + TDR_CNT_W'(1);
          if (echo_detect || tdr_cnt_ff == TDR_TIMEOUT) begin
            tdr_len_ff   <= tdr_cnt_ff;
            tdr_state_ff <= TDR_DONE;
          end
        end
        TDR_DONE: tdr_state_ff <= TDR_IDLE;
      endcase
    end
  end

  // done flag: set wins over clear by a new enable write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdr_done_ff <= 1'b0;
    end else if (tdr_state_ff == TDR_DONE) begin
      tdr_done_ff <= 1'b1;
    end else if (wr_en && paddr == TDR_CTRL_OFF && pwdata[TDR_EN_BIT]) begin
      tdr_done_ff <= 1'b0;
    end
  end

  // line-side outputs and pulse steering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdr_pulse_tx <= 1'b0;
      tdr_pulse_rx <= 1'b0;
      link_drop    <= 1'b0;
      tx_power_on  <= 1'b1;
      line_txd     <= '0;
      line_txen    <= 1'b0;
    end else begin
      // crossover bit low means straight-through pair
      tdr_pulse_tx <= (tdr_state_ff == TDR_PULSE) && !special_ctrl_ff[PAIR_SEL_BIT];
      tdr_pulse_rx <= (tdr_state_ff == TDR_PULSE) && special_ctrl_ff[PAIR_SEL_BIT];
      link_drop    <= tdr_en_ff || tdr_state_ff != TDR_IDLE;
      tx_power_on  <= !near_loop;
      if (far_loop) begin
        line_txd  <= line_rxd;
        line_txen <= line_rxdv;
      end else if (near_loop) begin
        line_txd  <= '0;
        line_txen <= 1'b0;
      end else begin
        line_txd  <= mac_txd;
        line_txen <= mac_txen;
      end
    end
  end

  // mac-side outputs; near loop taps mac_txd before the coding stage, one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rxd  <= '0;
      mac_rxdv <= 1'b0;
      mac_col  <= 1'b0;
    end else if (far_loop) begin
      mac_rxd  <= '0;
      mac_rxdv <= 1'b0;
      mac_col  <= 1'b0;
    end else if (near_loop) begin
      mac_rxd  <= mac_txd;
      mac_rxdv <= mac_txen;
      mac_col  <= basic_ctrl_ff[COLTEST_BIT] && col_test && mac_txen;
    end else begin
      mac_rxd  <= line_rxd;
      mac_rxdv <= line_rxdv;
      // gating with txen drops col on its first low sample; timer plus this register alone misses 4 bit times
      mac_col  <= basic_ctrl_ff[COLTEST_BIT] ? (col_test && mac_txen) : line_col;
    end
  end

  col_test_timer u_col_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (basic_ctrl_ff[COLTEST_BIT]),
    .txen     (mac_txen),
    .col_test (col_test)
  );

  // read mux; cable length reads zero without a 100 Mb link
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    mapped    = 1'b1;
    unique case (paddr)
      BASIC_CTRL_OFF:   nxt_rdata[15:0] = basic_ctrl_ff;
      MODE_CTRL_OFF:    nxt_rdata[15:0] = mode_ctrl_ff;
      SPECIAL_CTRL_OFF: nxt_rdata[15:0] = special_ctrl_ff;
      TDR_CTRL_OFF:     nxt_rdata[15:0] = {tdr_en_ff, 6'h00, tdr_done_ff, tdr_len_ff};
      CABLE_LEN_OFF:    nxt_rdata[CBL_W-1:0] = (link_up && link_100) ? cable_length_code : 4'h0;
      LINK_STAT_OFF:    nxt_rdata[1:0] = {link_100, link_up};
      default:          mapped = 1'b0;
    endcase
  end

  // no wait state: answer on the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= nxt_rdata;
      end
    end
  end
endmodule

// File: cable_diag_loopback_chk.sv
`timescale 1ns/10ps
module cable_diag_chk (
  // watched ports, grouped to keep the checker short
  input wire logic       pclk, presetn, psel, penable, pready,
  input wire logic       mac_txen, mac_col, line_txen, tx_power_on,
  input wire logic       tdr_pulse_tx, tdr_pulse_rx, link_drop,
  input wire logic [3:0] mac_txd, mac_rxd
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_ans; psel && !penable |=> pready; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("late ready");
  property p_loop_rx; !tx_power_on && $past(!tx_power_on) |-> mac_rxd == $past(mac_txd); endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loop data");
  property p_tx_off; !tx_power_on |-> !line_txen; endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx in loop");
  property p_pulse_excl; tdr_pulse_tx |-> !tdr_pulse_rx; endproperty
  a_pulse_excl: assert property (p_pulse_excl) else $error("two pairs");
  property p_pulse_one; tdr_pulse_tx || tdr_pulse_rx |=> !tdr_pulse_tx && !tdr_pulse_rx; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
  property p_drop; tdr_pulse_tx || tdr_pulse_rx |-> link_drop [*2]; endproperty
  a_drop: assert property (p_drop) else $error("link kept");
  property p_col_cause; $rose(mac_col) |-> $past(mac_txen, 2); endproperty
  a_col_cause: assert property (p_col_cause) else $error("col no txen");
  property p_col_off; $fell(mac_txen) |-> ##[0:1] !mac_col; endproperty
  a_col_off: assert property (p_col_off) else $error("col stuck");
  c_loop: cover property (!tx_power_on && mac_txen);
  c_rx_pair: cover property (tdr_pulse_rx);
  c_col: cover property (mac_col);
endmodule
bind cable_diag_loopback cable_diag_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .mac_txen,
  .mac_col, .line_txen, .tx_power_on, .tdr_pulse_tx, .tdr_pulse_rx, .link_drop, .mac_txd, .mac_rxd);

// File: cable_diag_pkg.sv
package cable_diag_pkg;
  // register byte offsets on apb (printed indices times four)
  localparam logic [7:0] BASIC_CTRL_OFF   = 8'h00;
  localparam logic [7:0] MODE_CTRL_OFF    = 8'h44;
  localparam logic [7:0] TDR_CTRL_OFF     = 8'h64;
  localparam logic [7:0] SPECIAL_CTRL_OFF = 8'h6C;
  localparam logic [7:0] CABLE_LEN_OFF    = 8'h70;
  localparam logic [7:0] LINK_STAT_OFF    = 8'h80;
  // basic control fields
  localparam int LOOPBACK_BIT  = 14;
  localparam int SPEED_BIT     = 13;
  localparam int ANEG_BIT      = 12;
  localparam int DUPLEX_BIT    = 8;
  localparam int COLTEST_BIT   = 7;
  // mode control fields
  localparam int FAR_LOOP_BIT  = 9;
  // tdr control/status fields
  localparam int TDR_EN_BIT    = 15;
  localparam int TDR_DONE_BIT  = 8;
  localparam int TDR_LEN_MSB   = 7;
  // special control fields
  localparam int PAIR_SEL_BIT  = 15;
  localparam int AUTO_XOVER_BIT = 14;
  // reset values
  localparam logic [15:0] BASIC_CTRL_RST   = 16'h3100;
  localparam logic [15:0] MODE_CTRL_RST    = 16'h0000;
  localparam logic [15:0] SPECIAL_CTRL_RST = 16'h4000;
  // timing: bit time at 100 Mb is 10 ns, at 10 Mb 100 ns
  localparam int CLK_PERIOD_NS   = 25;
  localparam int COL_ON_BITS     = 512;
  localparam int COL_OFF_BITS    = 4;
  localparam int BIT_NS_100      = 10;
  // assertion delay: longest, round down
  localparam int COL_ON_CYC  = (COL_ON_BITS * BIT_NS_100) / CLK_PERIOD_NS;
  // release delay: longest, round down, at least one cycle
  localparam int COL_OFF_CYC = ((COL_OFF_BITS * BIT_NS_100) / CLK_PERIOD_NS < 1) ? 1 :
                               (COL_OFF_BITS * BIT_NS_100) / CLK_PERIOD_NS;
  localparam int COL_CNT_W   = 10;
  localparam logic [COL_CNT_W-1:0] COL_ON_DLY = COL_CNT_W'(COL_ON_CYC / 4);
  localparam logic [COL_CNT_W-1:0] COL_OFF_DLY = COL_CNT_W'(COL_OFF_CYC);
  localparam int TDR_CNT_W = 8;
  localparam logic [TDR_CNT_W-1:0] TDR_TIMEOUT = 8'hFF;
  localparam int CBL_W = 4;
  typedef enum logic [1:0] {TDR_IDLE, TDR_PULSE, TDR_WAIT, TDR_DONE} tdr_state_t;
endpackage

// File: cable_line_model.sv
`timescale 1ns/10ps
module cable_line_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pulses from the device, echo distance in cycles
  input  wire logic       tdr_pulse_tx,
  input  wire logic       tdr_pulse_rx,
  input  wire logic [7:0] echo_dly,
  // line side back to the device
  output logic            echo_detect,
  output logic [3:0]      line_rxd,
  output logic            line_rxdv
);
  logic [7:0] cnt_ff;
  // a zero distance models a matched cable: no echo ever comes back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff      <= 8'h00;
      echo_detect <= 1'b0;
    end else begin
      echo_detect <= (cnt_ff == 8'h01);
      if (tdr_pulse_tx || tdr_pulse_rx) cnt_ff <= echo_dly;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
  end
  // data changes every cycle so a stale value never matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {line_rxd, line_rxdv} <= 5'h00;
    else {line_rxd, line_rxdv} <= {line_rxd + 4'h7, ~line_rxdv};
  end
endmodule

// File: col_test_timer.sv
`timescale 1ns/10ps
module col_test_timer
  import cable_diag_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic enable,
  input  wire logic txen,
  // result
  output logic      col_test
);
  logic [COL_CNT_W-1:0] cnt_ff;
  logic                 col_ff;

  assign col_test = col_ff;

  // raise after a short settle well inside the 512 bit limit, drop within 4 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      col_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= '0;
      col_ff <= 1'b0;
    end else if (txen != col_ff) begin
      if (cnt_ff >= (txen ? COL_ON_DLY : COL_OFF_DLY) - COL_CNT_W'(1)) begin
        col_ff <= txen;
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + COL_CNT_W'(1);
      end
    end else begin
      cnt_ff <= '0;
    end
  end
endmodule

// File: tb_cable_diag_loopback.sv
`timescale 1ns/10ps
module tb_cable_diag_loopback;
  import cable_diag_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
  logic rmii_mode = 0, mac_txen = 0, line_col = 0, link_up = 0, link_100 = 0;
  logic mac_rxdv, mac_col, line_txen, tx_power_on, tdr_pulse_tx, tdr_pulse_rx, link_drop;
  logic line_rxdv, echo_detect;
  logic [7:0] paddr = 0, echo_dly = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic [3:0] mac_txd = 0, mac_rxd, line_txd, line_rxd, lr, cable_length_code = 0;
  int fails = 0, n_checks = 0, seed = 32'h98e19f16, i, j, n;
  always #12.5 pclk = ~pclk;
  cable_diag_loopback dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rmii_mode, .mac_txd, .mac_txen, .mac_rxd, .mac_rxdv, .mac_col, .line_rxd,
    .line_rxdv, .line_col, .link_up, .link_100, .cable_length_code, .echo_detect, .line_txd,
    .line_txen, .tx_power_on, .tdr_pulse_tx, .tdr_pulse_rx, .link_drop);
  cable_line_model far_end (.pclk, .presetn, .tdr_pulse_tx, .tdr_pulse_rx, .echo_dly,
    .echo_detect, .line_rxd, .line_rxdv);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; result left in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) fails++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  function logic [31:0] len_exp(input logic up, input logic f100, input logic [3:0] c);
    return (up && f100) ? {28'h0, c} : 32'h0;
  endfunction
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, BASIC_CTRL_OFF, 0); chk(rd, {16'h0, BASIC_CTRL_RST});
    apb(0, SPECIAL_CTRL_OFF, 0); chk(rd, {16'h0, SPECIAL_CTRL_RST});
    apb(0, MODE_CTRL_OFF, 0); chk(rd, {16'h0, MODE_CTRL_RST});
    apb(0, 8'hF0, 0); chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1, BASIC_CTRL_OFF, 32'h4000);
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      v = $random(seed);
      mac_txd <= v[3:0];
      mac_txen <= v[4];
      @(posedge pclk);
      #1;
      chk({mac_rxdv, mac_rxd}, v[4:0]);
      chk({tx_power_on, line_txen, mac_col}, 0);
    end
    apb(1, BASIC_CTRL_OFF, 32'h0080);
    @(posedge pclk) mac_txen <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mac_col !== 1'b1 && n < 300);
    chk(n <= 205, 1);
    mac_txen <= 0;
    repeat (1) @(posedge pclk);
    #1 chk(mac_col, 0);
    apb(1, BASIC_CTRL_OFF, 0);
    // normal, far loop, far loop refused without rmii
    for (j = 0; j < 3; j++) begin
      apb(1, MODE_CTRL_OFF, j ? 32'h200 : 0);
      rmii_mode <= (j < 2);
      repeat (3) @(posedge pclk);
      v = $random(seed);
      mac_txd <= v[3:0];
      #1 lr = line_rxd;
      @(posedge pclk);
      #1;
      chk(line_txd, (j == 1) ? lr : v[3:0]);
      chk(mac_rxd, (j == 1) ? 4'h0 : lr);
    end
    apb(1, MODE_CTRL_OFF, 0);
    v = $random(seed);
    for (j = 0; j < 2; j++) begin
      {link_up, link_100, cable_length_code} <= {1'b1, j[0], v[3:0]};
      apb(0, CABLE_LEN_OFF, 0); chk(rd, len_exp(1, j[0], v[3:0]));
    end
    apb(1, BASIC_CTRL_OFF, 32'h2100);
    for (j = 0; j < 3; j++) begin
      apb(1, SPECIAL_CTRL_OFF, j[0] ? 32'h8000 : 0);
      // third run is a matched cable: no echo, so the length runs to the timeout
      echo_dly <= (j == 2) ? 8'd0 : 8'd20 + 8'(j * 17);
      apb(1, TDR_CTRL_OFF, 32'h8000);
      n = 0;
      while (tdr_pulse_tx !== 1'b1 && tdr_pulse_rx !== 1'b1 && n < 50) @(posedge pclk) #1 n++;
      chk({tdr_pulse_rx, tdr_pulse_tx, link_drop}, {j[0], !j[0], 1'b1});
      do apb(0, TDR_CTRL_OFF, 0); while (rd[TDR_DONE_BIT] !== 1'b1 && ++n < 150);
      chk(rd[15:8], 8'h01);
      if (j < 2) chk(rd[7:0] + 8'd2 - echo_dly <= 8'd4, 1);
      else chk(rd[7:0], TDR_TIMEOUT);
    end
    give_verdict;
  end
  initial begin
    #1000000;
    fails++;
    give_verdict;
  end
endmodule
